// *** rtl/sub_exec_pkg.sv ***
// package: encodings, field layout, flag positions and apb map
package sub_exec_pkg;
  // ---------------------------------------------------------------
  // instruction word layout
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_SUB_ACC_FROM_FILE = 6'h17;
  localparam int         OPC_MSB               = 15;
  localparam int         OPC_LSB               = 10;
  localparam int         DEST_BIT              = 9;
  localparam int         BANK_BIT              = 8;
  localparam int         ADDR_MSB              = 7;
  // ---------------------------------------------------------------
  // status flag bit positions
  // ---------------------------------------------------------------
  localparam int         FLG_CARRY             = 0;
  localparam int         FLG_DIGIT             = 1;
  localparam int         FLG_ZERO              = 2;
  localparam int         FLG_OVF               = 3;
  localparam int         FLG_NEG               = 4;
  // ---------------------------------------------------------------
  // apb register byte offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR             = 8'h00;
  localparam logic [7:0] OFS_ACC               = 8'h04;
  localparam logic [7:0] OFS_STATUS            = 8'h08;
  localparam logic [7:0] OFS_BANK              = 8'h0c;
  localparam logic [7:0] OFS_FILE_ADDR         = 8'h10;
  localparam logic [7:0] OFS_FILE_DATA         = 8'h14;
  localparam logic [7:0] OFS_STATE             = 8'h18;
  localparam logic [7:0] ACC_RST               = 8'h00;
  localparam logic [4:0] STATUS_RST            = 5'h00;
  localparam logic [3:0] BANK_RST              = 4'h0;
  // ---------------------------------------------------------------
  // phase states and alu result
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PH_IDLE   = 3'b000,
    PH_DECODE = 3'b001,
    PH_READ   = 3'b010,
    PH_PROC   = 3'b011,
    PH_WRITE  = 3'b100
  } phase_t;
  typedef struct packed
  {
    logic [7:0] diff;
    logic [4:0] flags;
  } alu_res_t;
endpackage

// *** rtl/sub_exec.sv ***
// subtract-accumulator-from-file execution unit with apb access
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// - result is file minus accumulator; all five status flags updated
// - destination bit 0: result to accumulator, file register untouched
// - destination bit 1: result written back into the file register
// - one instruction cycle of four phases; first phase decodes
// - phase two reads file, three subtracts, four writes destination
module sub_exec
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy,
  output logic             illegal_op
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0]                 file_mem [0:4095];
  logic [7:0]                 acc_ff;
  logic [4:0]                 status_ff;
  logic [3:0]                 bank_ff;
  logic [11:0]                fadr_ff;
  logic [15:0]                instr_ff;
  logic                       dest_ff;
  logic [11:0]                eadr_ff;
  logic [7:0]                 opnd_ff;
  sub_exec_pkg::alu_res_t     res_ff;
  sub_exec_pkg::phase_t       phase_ff;
  logic                       illegal_ff;
  logic [7:0]                 rdata_ff;
  logic                       wr_acc;
  logic                       rd_acc;
  logic                       start;
  sub_exec_pkg::alu_res_t     alu;

  // ---------------------------------------------------------------
  // subtract and flags
  // ---------------------------------------------------------------
  function automatic sub_exec_pkg::alu_res_t sub_f_w
  (
    input logic [7:0] f,
    input logic [7:0] w
  );
    sub_exec_pkg::alu_res_t r;
    logic [8:0]             full;
    logic [4:0]             low;
    r    = '0;
    full = {1'b0, f} + {1'b0, ~w} + 9'h001;
    low  = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
    r.diff = full[7:0];
    r.flags[sub_exec_pkg::FLG_CARRY] = full[8];
    r.flags[sub_exec_pkg::FLG_DIGIT] = low[4];
    r.flags[sub_exec_pkg::FLG_ZERO]  = (full[7:0] == 8'h00);
    r.flags[sub_exec_pkg::FLG_OVF]   = (f[7] != w[7]) && (full[7] != f[7]);
    r.flags[sub_exec_pkg::FLG_NEG]   = full[7];
    return r;
  endfunction

  assign alu = sub_f_w(opnd_ff, acc_ff);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // zero-wait slave; writes ignored while an instruction runs
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !penable && !pwrite;
  assign start   = wr_acc && (paddr == sub_exec_pkg::OFS_INSTR)
                   && (phase_ff == sub_exec_pkg::PH_IDLE);
  assign busy       = (phase_ff != sub_exec_pkg::PH_IDLE);
  assign illegal_op = illegal_ff;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 8'h00;
    else if (rd_acc)
      rdata_ff <= file_mem[fadr_ff];
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      sub_exec_pkg::OFS_INSTR:     prdata = {16'h0000, instr_ff};
      sub_exec_pkg::OFS_ACC:       prdata = {24'h000000, acc_ff};
      sub_exec_pkg::OFS_STATUS:    prdata = {27'h0000000, status_ff};
      sub_exec_pkg::OFS_BANK:      prdata = {28'h0000000, bank_ff};
      sub_exec_pkg::OFS_FILE_ADDR: prdata = {20'h00000, fadr_ff};
      sub_exec_pkg::OFS_FILE_DATA: prdata = {24'h000000, rdata_ff};
      sub_exec_pkg::OFS_STATE:     prdata = {28'h0000000, illegal_ff,
                                             phase_ff};
      default:                     prdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      phase_ff <= sub_exec_pkg::PH_IDLE;
    else
    begin
      unique case (phase_ff)
        sub_exec_pkg::PH_IDLE:
          if (start)
            phase_ff <= sub_exec_pkg::PH_DECODE;
        sub_exec_pkg::PH_DECODE:
          if (instr_ff[sub_exec_pkg::OPC_MSB:sub_exec_pkg::OPC_LSB]
              == sub_exec_pkg::OPC_SUB_ACC_FROM_FILE)
            phase_ff <= sub_exec_pkg::PH_READ;
          else
            phase_ff <= sub_exec_pkg::PH_IDLE;
        sub_exec_pkg::PH_READ:  phase_ff <= sub_exec_pkg::PH_PROC;
        sub_exec_pkg::PH_PROC:  phase_ff <= sub_exec_pkg::PH_WRITE;
        sub_exec_pkg::PH_WRITE: phase_ff <= sub_exec_pkg::PH_IDLE;
        default:                phase_ff <= sub_exec_pkg::PH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // instruction capture and decode
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      instr_ff   <= 16'h0000;
      dest_ff    <= 1'b0;
      eadr_ff    <= 12'h000;
      illegal_ff <= 1'b0;
    end
    else if (start)
      instr_ff <= pwdata[15:0];
    else if (phase_ff == sub_exec_pkg::PH_DECODE)
    begin
      // bank bit 0 takes the access bank (page 0), 1 the bank register
      dest_ff    <= instr_ff[sub_exec_pkg::DEST_BIT];
      eadr_ff    <= instr_ff[sub_exec_pkg::BANK_BIT]
                    ? {bank_ff, instr_ff[sub_exec_pkg::ADDR_MSB:0]}
                    : {4'h0, instr_ff[sub_exec_pkg::ADDR_MSB:0]};
      illegal_ff <= instr_ff[sub_exec_pkg::OPC_MSB:sub_exec_pkg::OPC_LSB]
                    != sub_exec_pkg::OPC_SUB_ACC_FROM_FILE;
    end
  end

  // ---------------------------------------------------------------
  // operand read and process
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      opnd_ff <= 8'h00;
      res_ff  <= '0;
    end
    else if (phase_ff == sub_exec_pkg::PH_READ)
      opnd_ff <= file_mem[eadr_ff];
    else if (phase_ff == sub_exec_pkg::PH_PROC)
      res_ff <= alu;
  end

  // ---------------------------------------------------------------
  // write-back: accumulator, status, file memory
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      acc_ff <= sub_exec_pkg::ACC_RST;
    else if (phase_ff == sub_exec_pkg::PH_WRITE && !dest_ff)
      acc_ff <= res_ff.diff;
    else if (wr_acc && paddr == sub_exec_pkg::OFS_ACC && !busy)
      acc_ff <= pwdata[7:0];
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      status_ff <= sub_exec_pkg::STATUS_RST;
    else if (phase_ff == sub_exec_pkg::PH_WRITE)
      status_ff <= res_ff.flags;
    else if (wr_acc && paddr == sub_exec_pkg::OFS_STATUS && !busy)
      status_ff <= pwdata[4:0];
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bank_ff <= sub_exec_pkg::BANK_RST;
      fadr_ff <= 12'h000;
    end
    else if (wr_acc && !busy)
    begin
      if (paddr == sub_exec_pkg::OFS_BANK)
        bank_ff <= pwdata[3:0];
      if (paddr == sub_exec_pkg::OFS_FILE_ADDR)
        fadr_ff <= pwdata[11:0];
    end
  end

  // memory has no reset; its contents are software's to load
  always_ff @(posedge ref_clk)
  begin
    if (phase_ff == sub_exec_pkg::PH_WRITE && dest_ff)
      file_mem[eadr_ff] <= res_ff.diff;
    else if (wr_acc && paddr == sub_exec_pkg::OFS_FILE_DATA && !busy)
      file_mem[fadr_ff] <= pwdata[7:0];
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_acc_dest_zero: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE && !dest_ff
    |=> acc_ff == $past(res_ff.diff))
    else $error("acc not written for dest 0");
  chk_acc_kept_one: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE && dest_ff |=> $stable(acc_ff))
    else $error("acc changed for dest 1");
  chk_file_dest_one: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE && dest_ff
    |=> file_mem[$past(eadr_ff)] == $past(res_ff.diff))
    else $error("file not written for dest 1");
  chk_phase_order: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_READ
    |=> phase_ff == sub_exec_pkg::PH_PROC
    ##1 phase_ff == sub_exec_pkg::PH_WRITE
    ##1 phase_ff == sub_exec_pkg::PH_IDLE)
    else $error("phase order broken");
  chk_decode_first: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    start |=> phase_ff == sub_exec_pkg::PH_DECODE)
    else $error("decode not first phase");
  chk_opcode_gate: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_DECODE
    && instr_ff[sub_exec_pkg::OPC_MSB:sub_exec_pkg::OPC_LSB]
       != sub_exec_pkg::OPC_SUB_ACC_FROM_FILE
    |=> phase_ff == sub_exec_pkg::PH_IDLE && illegal_ff)
    else $error("bad opcode executed");
  chk_flags_zero: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE
    |=> status_ff[sub_exec_pkg::FLG_ZERO] == ($past(res_ff.diff) == 8'h00))
    else $error("zero flag wrong");
  chk_diff_value: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_PROC
    |=> res_ff.diff == 8'($past(opnd_ff) - $past(acc_ff)))
    else $error("difference wrong");
  // carry means no borrow: file operand at least the accumulator
  chk_carry_flag: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE
    |=> status_ff[sub_exec_pkg::FLG_CARRY]
        == (opnd_ff >= $past(acc_ff)))
    else $error("carry flag wrong");
  chk_digit_flag: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE
    |=> status_ff[sub_exec_pkg::FLG_DIGIT]
        == (opnd_ff[3:0] >= $past(acc_ff[3:0])))
    else $error("digit carry flag wrong");
  chk_neg_flag: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE
    |=> status_ff[sub_exec_pkg::FLG_NEG] == res_ff.diff[7])
    else $error("negative flag wrong");
  chk_ovf_flag: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE
    |=> status_ff[sub_exec_pkg::FLG_OVF]
        == ((opnd_ff[7] != $past(acc_ff[7]))
            && (res_ff.diff[7] != opnd_ff[7])))
    else $error("overflow flag wrong");
  chk_file_kept_zero: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_WRITE && !dest_ff
    |=> file_mem[eadr_ff] == opnd_ff)
    else $error("file changed for dest 0");
  chk_operand_read: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_READ
    |=> opnd_ff == file_mem[eadr_ff])
    else $error("operand not read in second phase");
  chk_busy_span: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    start && pwdata[sub_exec_pkg::OPC_MSB:sub_exec_pkg::OPC_LSB]
             == sub_exec_pkg::OPC_SUB_ACC_FROM_FILE
    |=> busy [*4] ##1 !busy)
    else $error("instruction not four phases long");
  chk_dest_capture: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    phase_ff == sub_exec_pkg::PH_DECODE
    |=> dest_ff == $past(instr_ff[sub_exec_pkg::DEST_BIT])
        && eadr_ff[7:0] == $past(instr_ff[7:0]))
    else $error("destination or address not captured");
endmodule

// *** testbench/file_mirror.sv ***
// file memory mirror that snoops host writes over apb
`timescale 1ns/1ns
module file_mirror
(
  input  wire logic        ref_clk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic        pready,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [11:0] look_addr,
  output logic      [7:0]  look_data
);
  // host writes only: results written back by the unit are not seen
  logic [7:0]  mem_ff [4096];
  logic [11:0] fa_ff;
  logic        wr;
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge ref_clk)
  begin
    if (wr && paddr == sub_exec_pkg::OFS_FILE_ADDR)
      fa_ff <= pwdata[11:0];
    if (wr && paddr == sub_exec_pkg::OFS_FILE_DATA)
      mem_ff[fa_ff] <= pwdata[7:0];
  end
  assign look_data = mem_ff[look_addr];
endmodule

// *** testbench/tb_sub_exec.sv ***
// testbench for the subtract execution unit
`timescale 1ns/1ns
module tb_sub_exec;
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        illegal_op;
  logic [11:0] look_addr = 12'h000;
  logic [7:0]  look_data;
  logic [31:0] q;
  int          err_total  = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  // f, w, dest, bank select, bank, file address
  logic [29:0] vec [6] = '{
    {8'h03, 8'h02, 1'b1, 1'b0, 4'h0, 8'h20},
    {8'h02, 8'h02, 1'b0, 1'b0, 4'h0, 8'h21},
    {8'h01, 8'h02, 1'b1, 1'b1, 4'h3, 8'h5f},
    {8'h80, 8'h01, 1'b0, 1'b1, 4'h5, 8'h60},
    {8'h7f, 8'hff, 1'b1, 1'b0, 4'h9, 8'hff},
    {8'h10, 8'h01, 1'b0, 1'b1, 4'hf, 8'h00}};
  always #2 ref_clk = ~ref_clk;
  sub_exec sub_exec_i
  (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .busy       (busy),
    .illegal_op (illegal_op)
  );
  file_mirror file_mirror_i
  (
    .ref_clk   (ref_clk),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .pready    (pready),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .look_addr (look_addr),
    .look_data (look_data)
  );
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard: whole run needs a few hundred cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // waits for pready as long as it takes; only the hang guard ends it
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    cmp({31'h0, pslverr}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_case(input logic [29:0] v);
    logic [7:0]  f, w, fa, r;
    logic        d, a;
    logic [3:0]  b;
    logic [11:0] ta;
    logic [4:0]  st;
    int          n;
    {f, w, d, a, b, fa} = v;
    ta = a ? {b, fa} : {4'h0, fa};
    r  = f - w;
    st = 5'h00;
    st[sub_exec_pkg::FLG_CARRY] = f >= w;
    st[sub_exec_pkg::FLG_DIGIT] = f[3:0] >= w[3:0];
    st[sub_exec_pkg::FLG_ZERO]  = r == 8'h00;
    st[sub_exec_pkg::FLG_OVF]   = (f[7] ^ w[7]) & (r[7] ^ f[7]);
    st[sub_exec_pkg::FLG_NEG]   = r[7];
    apb(1'b1, sub_exec_pkg::OFS_BANK, {28'h0, b});
    apb(1'b1, sub_exec_pkg::OFS_FILE_ADDR, {24'h0, fa});
    apb(1'b1, sub_exec_pkg::OFS_FILE_DATA, {24'h0, ~f});
    apb(1'b1, sub_exec_pkg::OFS_FILE_ADDR, {20'h0, ta});
    apb(1'b1, sub_exec_pkg::OFS_FILE_DATA, {24'h0, f});
    apb(1'b1, sub_exec_pkg::OFS_ACC, {24'h0, w});
    apb(1'b1, sub_exec_pkg::OFS_INSTR,
        {16'h0, sub_exec_pkg::OPC_SUB_ACC_FROM_FILE, d, a, fa});
    n = 0;
    repeat (8)
    begin
      #1;
      if (busy === 1'b1)
        n++;
      @(posedge ref_clk);
    end
    cmp(32'(n), 32'h4);
    cmp({31'h0, illegal_op}, 32'h0);
    apb(1'b0, sub_exec_pkg::OFS_ACC, 32'h0);
    cmp(q, {24'h0, d ? w : r});
    apb(1'b0, sub_exec_pkg::OFS_STATUS, 32'h0);
    cmp(q, {27'h0, st});
    apb(1'b0, sub_exec_pkg::OFS_FILE_DATA, 32'h0);
    cmp(q, {24'h0, d ? r : f});
    apb(1'b0, sub_exec_pkg::OFS_STATE, 32'h0);
    cmp(q, 32'h0);
    apb(1'b0, sub_exec_pkg::OFS_BANK, 32'h0);
    cmp(q, {28'h0, b});
    apb(1'b0, sub_exec_pkg::OFS_FILE_ADDR, 32'h0);
    cmp(q, {20'h0, ta});
    if (a && b != 4'h0)
    begin
      look_addr = {4'h0, fa};
      apb(1'b1, sub_exec_pkg::OFS_FILE_ADDR, {24'h0, fa});
      apb(1'b0, sub_exec_pkg::OFS_FILE_DATA, 32'h0);
      cmp(q, {24'h0, look_data});
    end
    $display("test f=%h w=%h d=%b a=%b done", f, w, d, a);
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, sub_exec_pkg::OFS_ACC, 32'h0);
    cmp(q, {24'h0, sub_exec_pkg::ACC_RST});
    apb(1'b0, sub_exec_pkg::OFS_STATUS, 32'h0);
    cmp(q, {27'h0, sub_exec_pkg::STATUS_RST});
    apb(1'b0, 8'h40, 32'h0);
    cmp(q, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
      run_case(vec[i]);
    // wrong opcode must start nothing and flag itself
    apb(1'b1, sub_exec_pkg::OFS_ACC, 32'h33);
    apb(1'b1, sub_exec_pkg::OFS_INSTR, 32'hfe00);
    repeat (8) @(posedge ref_clk);
    cmp({31'h0, illegal_op}, 32'h1);
    apb(1'b0, sub_exec_pkg::OFS_ACC, 32'h0);
    cmp(q, 32'h33);
    apb(1'b0, sub_exec_pkg::OFS_STATE, 32'h0);
    cmp(q, 32'h8);
    apb(1'b0, sub_exec_pkg::OFS_INSTR, 32'h0);
    cmp(q, 32'h0000fe00);
    $display("test wrong opcode done");
    // reset again in mid-run: error flag and accumulator must clear
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    cmp({31'h0, illegal_op}, 32'h0);
    apb(1'b0, sub_exec_pkg::OFS_ACC, 32'h0);
    cmp(q, {24'h0, sub_exec_pkg::ACC_RST});
    apb(1'b0, sub_exec_pkg::OFS_STATE, 32'h0);
    cmp(q, 32'h0);
    $display("test mid-run reset done");
    for (int i = 4; i < 6; i++)
      run_case(vec[i]);
    conclude();
  end
endmodule
